//--- tat_pkg.sv
// Constants, types and state layout of the thermostat alarm block
//------------------------------------------------------------------
// Operation
//------------------------------------------------------------------
// Operation
// - Alarm output powers up active low
// - Power-up settings give standalone thermostat
// - Comparator mode checks both setpoints each result
// - Comparator alarm asserts after consecutive over-limit faults
// - Comparator alarm clears below hysteresis setpoint
// - Comparator alarm unchanged on shutdown entry
// - Interrupt alarm fires after consecutive over-limit faults
// - Interrupt alarm cleared by any register read
// - Re-arm fires after consecutive below-hysteresis faults
// - Fault count in config bits 4 and 3
// - Codes map to 1, 2, 4, 6 faults
// - Fault-count bits reset to zero
// - Shutdown finishes conversion, stores, then standby; standby here rises with the shutdown bit
// - Shutdown entry clears alarm in interrupt mode
// - Registers stay usable; writing zero resumes
// - Values are 9-bit two's complement, half degree
// - Codes follow reference degree mapping
// - Leftmost bit is the sign
// - Registers accessible any time, even converting
// - Mode bit zero comparator, one interrupt
// - Polarity bit selects alarm active level
// - Temperature sits in bits 15 to 7
// - Readable temperature not updated during read cycle
package tat_pkg;

  //----------------------------------------------------------------
  // Register indices
  //----------------------------------------------------------------
  localparam logic [1:0] TAT_IDX_TEMP = 2'h0;
  localparam logic [1:0] TAT_IDX_CONF = 2'h1;
  localparam logic [1:0] TAT_IDX_HYST = 2'h2;
  localparam logic [1:0] TAT_IDX_OVER = 2'h3;

  //----------------------------------------------------------------
  // Field positions
  //----------------------------------------------------------------
  localparam int TAT_CONF_SD = 0;
  localparam int TAT_CONF_MODE = 1;
  localparam int TAT_CONF_POL = 2;
  localparam int TAT_CONF_FT_LO = 3;
  localparam int TAT_CONF_FT_HI = 4;
  localparam int TAT_TEMP_LSB = 7;
  localparam int TAT_TEMP_MSB = 15;

  //----------------------------------------------------------------
  // Reset values
  //----------------------------------------------------------------
  localparam logic [4:0] TAT_CONF_RST = 5'h00;
  localparam logic [8:0] TAT_TEMP_RST = 9'h000;
  localparam logic [8:0] TAT_HYST_RST = 9'h096;
  localparam logic [8:0] TAT_OVER_RST = 9'h0a0;

  //----------------------------------------------------------------
  // Fault-count encodings
  //----------------------------------------------------------------
  localparam logic [2:0] TAT_FAULTS_1 = 3'h1;
  localparam logic [2:0] TAT_FAULTS_2 = 3'h2;
  localparam logic [2:0] TAT_FAULTS_4 = 3'h4;
  localparam logic [2:0] TAT_FAULTS_6 = 3'h6;

  // Converter side of the block
  typedef struct packed {
    logic done;
    logic [8:0] code;
  } tat_conv_t;

  // Register port request
  typedef struct packed {
    logic [1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } tat_req_t;

  typedef struct packed {
    logic [8:0] temp;
    logic [8:0] over;
    logic [8:0] hyst;
    logic [4:0] conf;
    logic alarm;
    logic look_low;
    logic [2:0] cnt;
    logic sd_prev;
    logic [15:0] rdata;
    logic busy_meta;
    logic busy_sync;
  } tat_state_t;

endpackage : tat_pkg

//--- tat_thermostat.sv
// Thermostat and alarm logic with its register file
//
// Implementation choices: the address-and-strobe port and the register addresses.
`timescale 1ns/100ps
module tat_thermostat
  import tat_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire tat_req_t req,
  output logic [15:0] read_data,
  // Converter
  input wire tat_conv_t conv,
  output logic conv_run,
  output logic standby,
  // Serial front end, asynchronous level
  input wire logic read_cycle_active,
  // Open-drain alarm pin
  output logic alarm_output_o,
  output logic alarm_output_oe_n
);

  //----------------------------------------------------------------
  // Helpers
  //----------------------------------------------------------------
  function automatic logic [2:0] faults_needed(input logic [1:0] sel);
    case (sel)
      2'b00: faults_needed = TAT_FAULTS_1;
      2'b01: faults_needed = TAT_FAULTS_2;
      2'b10: faults_needed = TAT_FAULTS_4;
      default: faults_needed = TAT_FAULTS_6;
    endcase
  endfunction : faults_needed

  function automatic logic [15:0] reg_image(input tat_state_t s,
                                            input logic [1:0] idx);
    reg_image = 16'h0000;
    case (idx)
      TAT_IDX_TEMP: reg_image[TAT_TEMP_MSB:TAT_TEMP_LSB] = s.temp;
      TAT_IDX_CONF: reg_image = {11'h000, s.conf};
      TAT_IDX_HYST: reg_image[TAT_TEMP_MSB:TAT_TEMP_LSB] = s.hyst;
      default: reg_image[TAT_TEMP_MSB:TAT_TEMP_LSB] = s.over;
    endcase
  endfunction : reg_image

  //----------------------------------------------------------------
  // State
  //----------------------------------------------------------------
  tat_state_t st_ff;
  tat_state_t nxt_st;

  logic mode_int;
  logic over_hit;
  logic under_hit;
  logic trip;
  logic [2:0] need;
  logic fire;
  logic sd_rise;

  always_comb begin
    nxt_st = st_ff;
    mode_int = st_ff.conf[TAT_CONF_MODE];
    need = faults_needed(st_ff.conf[TAT_CONF_FT_HI:TAT_CONF_FT_LO]);
    // Signed compare of 9-bit half-degree codes
    over_hit = $signed(conv.code) > $signed(st_ff.over);
    under_hit = $signed(conv.code) < $signed(st_ff.hyst);
    trip = st_ff.look_low ? under_hit : over_hit;
    fire = 1'b0;

    // Level from the serial domain, two flops before use
    nxt_st.busy_meta = read_cycle_active;
    nxt_st.busy_sync = st_ff.busy_meta;

    // Register port, open at all times
    if (req.rd) begin
      nxt_st.rdata = reg_image(st_ff, req.addr);
    end
    if (req.wr) begin
      case (req.addr)
        TAT_IDX_CONF: nxt_st.conf = req.wdata[4:0];
        TAT_IDX_HYST: nxt_st.hyst = req.wdata[TAT_TEMP_MSB:TAT_TEMP_LSB];
        TAT_IDX_OVER: nxt_st.over = req.wdata[TAT_TEMP_MSB:TAT_TEMP_LSB];
        default: nxt_st.temp = st_ff.temp;
      endcase
    end

    // Any read clears the interrupt-mode alarm
    if (mode_int && req.rd) begin
      nxt_st.alarm = 1'b0;
    end

    // Shutdown entry drops the interrupt-mode alarm only
    sd_rise = st_ff.conf[TAT_CONF_SD] && !st_ff.sd_prev;
    nxt_st.sd_prev = st_ff.conf[TAT_CONF_SD];
    if (sd_rise && mode_int) begin
      nxt_st.alarm = 1'b0;
    end // Comparator mode keeps the alarm

    // A finished result always reaches the comparators
    if (conv.done) begin
      if (!st_ff.busy_sync) begin
        nxt_st.temp = conv.code;
      end
      if (!mode_int) begin
        nxt_st.look_low = 1'b0;
        if (under_hit) begin
          nxt_st.alarm = 1'b0;
        end
        if (over_hit) begin
          if (st_ff.cnt + 3'h1 >= need) begin
            nxt_st.alarm = 1'b1;
            nxt_st.cnt = need;
          end else begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
          end
        end else begin
          nxt_st.cnt = 3'h0;
        end
      end else begin
        if (trip) begin
          if (st_ff.cnt + 3'h1 >= need) begin
            fire = 1'b1;
            nxt_st.cnt = 3'h0;
          end else begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
          end
        end else begin
          nxt_st.cnt = 3'h0;
        end
      end
    end

    // Firing alternates between over-limit and hysteresis runs;
    // an event in the read's cycle still wins over the clear
    if (fire) begin
      nxt_st.alarm = 1'b1;
      nxt_st.look_low = !st_ff.look_low;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      st_ff.temp <= TAT_TEMP_RST;
      st_ff.over <= TAT_OVER_RST;
      st_ff.hyst <= TAT_HYST_RST;
      st_ff.conf <= TAT_CONF_RST;
      st_ff.alarm <= 1'b0;
      st_ff.look_low <= 1'b0;
      st_ff.cnt <= 3'h0;
      st_ff.sd_prev <= 1'b0;
      st_ff.rdata <= 16'h0000;
      st_ff.busy_meta <= 1'b0;
      st_ff.busy_sync <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  //----------------------------------------------------------------
  // Outputs
  //----------------------------------------------------------------
  assign read_data = st_ff.rdata;
  // Converter finishes its current result before stopping
  assign conv_run = !st_ff.conf[TAT_CONF_SD];
  assign standby = st_ff.conf[TAT_CONF_SD];
  assign alarm_output_o = 1'b0;
  // Pull low when active with polarity 0, inactive with 1
  assign alarm_output_oe_n = !(st_ff.alarm ^ st_ff.conf[TAT_CONF_POL]);
  // Reset polarity 0 gives active low standalone

endmodule : tat_thermostat

//--- tat_checker.sv
// Assertions on the thermostat alarm block ports
`timescale 1ns/100ps
module tat_checker
  import tat_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port, converter, alarm pin
  input wire tat_req_t req,
  input wire tat_conv_t conv,
  input wire logic conv_run,
  input wire logic standby,
  input wire logic alarm_output_oe_n
);
  logic [4:0] cf_ff;
  logic [8:0] ov_ff, hy_ff;
  always_ff @(posedge clock) begin
    if (reset) begin
      cf_ff <= TAT_CONF_RST;
      ov_ff <= TAT_OVER_RST;
      hy_ff <= TAT_HYST_RST;
    end else if (req.wr) begin
      if (req.addr == TAT_IDX_CONF) cf_ff <= req.wdata[4:0];
      if (req.addr == TAT_IDX_OVER) ov_ff <= req.wdata[15:7];
      if (req.addr == TAT_IDX_HYST) hy_ff <= req.wdata[15:7];
    end
  end
  // Set alarm puts the pin at the polarity's level
  wire logic alm = alarm_output_oe_n == cf_ff[2];
  wire logic hot = conv.done && $signed(conv.code) > $signed(ov_ff);
  wire logic cold = conv.done && $signed(conv.code) < $signed(hy_ff);
  wire logic cmp = !cf_ff[1];
  wire logic cfw = req.wr && req.addr == TAT_IDX_CONF;
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  a_reset_idle: assert property (disable iff (1'b0)
    reset |=> alarm_output_oe_n && conv_run && !standby)
    else $error("not idle in reset");
  a_sd_follows: assert property (cfw |=>
    standby == $past(req.wdata[0]) && conv_run == !standby)
    else $error("shutdown bit lost");
  a_one_trip: assert property (
    hot && cmp && cf_ff[4:3] == 2'h0 |=> alm)
    else $error("no trip");
  a_cmp_clear: assert property (
    cold && !hot && cmp |=> !alm)
    else $error("no clear");
  a_cmp_sd_keep: assert property (
    cmp && cfw && req.wdata[2:0] == {cf_ff[2], 2'h1} && !conv.done
    |=> $stable(alarm_output_oe_n) [*2])
    else $error("shutdown moved alarm");
  a_int_sd_clear: assert property (
    !cmp && !standby && cfw && req.wdata[2:0] == {cf_ff[2], 2'h3}
    |-> ##[1:2] !alm)
    else $error("shutdown kept alarm");
  a_read_clear: assert property (
    !cmp && req.rd && !conv.done && alm |=> !alm)
    else $error("read kept alarm");
  a_pin_cause: assert property (
    $changed(alarm_output_oe_n)
    |-> $past(conv.done || req.rd || req.wr) || $past(req.wr, 2))
    else $error("alarm moved alone");
endmodule : tat_checker
bind tat_thermostat tat_checker chk (.clock(clock), .reset(reset),
  .req(req), .conv(conv), .conv_run(conv_run), .standby(standby),
  .alarm_output_oe_n(alarm_output_oe_n));

//--- tat_master.sv
// Register bus master model for the thermostat block
`timescale 1ns/100ps
module tat_master
  import tat_pkg::*;
(
  // Clock and read data
  input wire logic clock,
  input wire logic [15:0] read_data,
  // Requests
  output tat_req_t req
);
  initial req = '0;
  // Index rides with each strobe, so the pointer is always set first
  task automatic wr(input logic [1:0] a, input logic [15:0] v);
    @(posedge clock);
    req <= '{a, v, 1'b1, 1'b0};
    @(posedge clock);
    req.wr <= 1'b0;
    // Shutdown entry may land a cycle late
    repeat (2) @(posedge clock);
    #1;
  endtask : wr
  task automatic rd(input logic [1:0] a, output logic [15:0] v);
    @(posedge clock);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clock);
    req.rd <= 1'b0;
    #1 v = read_data;
  endtask : rd
endmodule : tat_master

//--- test_tat_thermostat.sv
// Testbench for the thermostat alarm block
`timescale 1ns/100ps
module test_tat_thermostat
  import tat_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic rca = 1'b0;
  tat_req_t req;
  tat_conv_t conv = '0;
  logic run, sb, po, oe_n;
  logic [15:0] rdata;
  int fail_count = 0;
  int total_checks = 0;
  // Pull-up holds the released pin high
  wire logic pin = oe_n ? 1'b1 : po;
  always #12.5 clock = ~clock;
  tat_master m (.clock(clock), .read_data(rdata), .req(req));
  tat_thermostat uut (.clock(clock), .reset(reset), .req(req),
    .read_data(rdata), .conv(conv), .conv_run(run), .standby(sb),
    .read_cycle_active(rca), .alarm_output_o(po),
    .alarm_output_oe_n(oe_n));
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: %h vs %h", $time, seen, exp);
    end
  endtask : check
  task automatic rc(input logic [1:0] a, input logic [15:0] exp);
    logic [15:0] v;
    m.rd(a, v);
    check(v, exp);
  endtask : rc
  task automatic cv(input logic [8:0] c, input logic exp);
    @(posedge clock);
    conv <= '{1'b1, c};
    @(posedge clock);
    conv.done <= 1'b0;
    @(posedge clock);
    #1 check(pin, exp);
  endtask : cv
  task automatic t_reset;
    logic [15:0] rv [4] = '{16'h0000, 16'h0000, 16'h4b00, 16'h5000};
    check(pin, 1'b1);
    for (int i = 0; i < 4; i++) rc(2'(i), rv[i]);
    cv(9'h0fa, 1'b0);
    cv(9'h000, 1'b1);
    $display("t_reset done");
  endtask : t_reset
  task automatic t_fault;
    int n;
    for (int ft = 0; ft < 4; ft++) begin
      n = ft == 3 ? 6 : 1 << ft;
      m.wr(TAT_IDX_CONF, 16'(ft << 3));
      repeat (n - 1) cv(9'h0fa, 1'b1);
      cv(9'h0a0, 1'b1);
      repeat (n - 1) cv(9'h0fa, 1'b1);
      cv(9'h0fa, 1'b0);
      cv(9'h000, 1'b1);
    end
    $display("t_fault done");
  endtask : t_fault
  task automatic t_int;
    m.wr(TAT_IDX_CONF, 16'h0002);
    cv(9'h0fa, 1'b0);
    cv(9'h0fa, 1'b0);
    rc(TAT_IDX_HYST, 16'h4b00);
    check(pin, 1'b1);
    cv(9'h0fa, 1'b1);
    cv(9'h192, 1'b0);
    m.wr(TAT_IDX_CONF, 16'h0003);
    check(pin, 1'b1);
    rc(TAT_IDX_TEMP, 16'hc900);
    m.wr(TAT_IDX_CONF, 16'h0000);
    check({sb, run}, 16'h0001);
    $display("t_int done");
  endtask : t_int
  task automatic t_sd;
    cv(9'h0fa, 1'b0);
    m.wr(TAT_IDX_CONF, 16'h0001);
    check(pin, 1'b0);
    check({sb, run}, 16'h0002);
    cv(9'h032, 1'b1);
    rc(TAT_IDX_TEMP, 16'h1900);
    m.wr(TAT_IDX_CONF, 16'h0000);
    $display("t_sd done");
  endtask : t_sd
  task automatic t_rca;
    // Read level held two 200 ns link periods, sampled by our clock
    @(posedge clock);
    rca <= 1'b1;
    repeat (16) @(posedge clock);
    cv(9'h0fa, 1'b0);
    rc(TAT_IDX_TEMP, 16'h1900);
    @(posedge clock);
    rca <= 1'b0;
    repeat (16) @(posedge clock);
    cv(9'h1b0, 1'b1);
    rc(TAT_IDX_TEMP, 16'hd800);
    $display("t_rca done");
  endtask : t_rca
  task automatic t_codes;
    logic [8:0] cd [4] = '{9'h0fa, 9'h001, 9'h1ff, 9'h192};
    foreach (cd[i]) begin
      m.wr(TAT_IDX_OVER, {cd[i], 7'h00});
      rc(TAT_IDX_OVER, {cd[i], 7'h00});
    end
    m.wr(TAT_IDX_OVER, 16'h0080);
    m.wr(TAT_IDX_HYST, 16'hff80);
    cv(9'h192, 1'b1);
    cv(9'h002, 1'b0);
    cv(9'h1ce, 1'b1);
    m.wr(TAT_IDX_CONF, 16'h00e4);
    rc(TAT_IDX_CONF, 16'h0004);
    check(pin, 1'b0);
    cv(9'h0fa, 1'b1);
    $display("t_codes done");
  endtask : t_codes
  task automatic test_done;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  initial begin
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    #1;
    t_reset();
    t_fault();
    t_int();
    t_sd();
    t_rca();
    t_codes();
    test_done();
  end
endmodule : test_tat_thermostat
